/* rtl/jump_decoder_pkg.sv */
// Behaviour
// - An unconditional absolute jump loads the program counter with the jump register picked by the select bit.
// - The unconditional absolute jump is bits 15..4 equal to 001110011010 and bits 2..0 equal to 101, with bit 3 as the register select.
// - The relative jump target is the instruction's own address plus a 5-bit two's-complement offset from -16 to 15.
// - The unconditional relative jump is bits 15..5 equal to 00101111000, with bits 4..0 as the signed offset.
// - A conditional absolute jump loads the program counter from the picked jump register only while its condition holds.
// - The conditional jump is bits 15..11 equal to 00111 and bits 3..0 zero, condition in bits 10..5, select in bit 4, codes 0-15 flag low, 16-31 flag high.
// - Codes 32-35 test terminal counts 1-4, 36 start low, 37 start high, 47 ALU request completed.
// - Codes 38-40 test short-cut drain low, 41-43 short-cut source low, 44-46 short-cut drain high.
// - Code 48 tests boost high, 49 boost low, 50-55 the six current feedbacks high, 56-61 the same low.
// - Code 62 tests the core's own current feedback high and code 63 tests it low.
package jump_decoder_pkg;

	localparam int PC_WIDTH = 10;

	localparam logic [11:0] FAR_HI_CODE   = 12'h39A;
	localparam logic [2:0]  FAR_LO_CODE   = 3'h5;
	localparam int          FAR_SEL_BIT   = 3;
	localparam logic [10:0] REL_HI_CODE   = 11'h178;
	localparam logic [4:0]  COND_HI_CODE  = 5'h07;
	localparam logic [3:0]  COND_LO_CODE  = 4'h0;
	localparam int          COND_SEL_BIT  = 4;
	localparam int          COND_CODE_LSB = 5;
	localparam int          OFFSET_WIDTH  = 5;

	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_JUMP0     = 8'h04;
	localparam logic [7:0]  REG_JUMP1     = 8'h08;
	localparam logic [7:0]  REG_STATUS    = 8'h0C;
	localparam logic [2:0]  OWN_SEL_RESET = 3'h0;
	localparam int          CURRENT_COUNT = 6;

	typedef enum logic [1:0] {
		KIND_NONE = 2'b00,
		KIND_FAR  = 2'b01,
		KIND_REL  = 2'b10,
		KIND_COND = 2'b11
	} jump_kind_e;

	typedef struct packed {
		logic [15:0] flags;
		logic [3:0]  terminalCount;
		logic        startIn;
		logic [2:0]  shortcutDrain;
		logic [2:0]  shortcutSource;
		logic        aluDone;
		logic        boostHigh;
		logic [5:0]  currentFeedback;
	} cond_inputs_s;

endpackage

/* rtl/condition_select.sv */
`timescale 1ns/1ps
`default_nettype none
module condition_select
	import jump_decoder_pkg::*;
(
	input  wire cond_inputs_s condIn,
	input  wire logic [2:0]   ownSelect,
	input  wire logic [5:0]   condCode,
	output logic              condTrue
);
	logic [63:0] condVector;
	logic        ownCurrent;

	// An out-of-range own selection reads as a low feedback rather than aliasing another one.
	assign ownCurrent = (ownSelect < 3'(CURRENT_COUNT)) ? condIn.currentFeedback[ownSelect] : 1'b0;

	always_comb begin
		condVector[15:0]  = ~condIn.flags;
		condVector[31:16] = condIn.flags;
		condVector[35:32] = condIn.terminalCount;
		condVector[36]    = ~condIn.startIn;
		condVector[37]    = condIn.startIn;
		condVector[40:38] = ~condIn.shortcutDrain;
		condVector[43:41] = ~condIn.shortcutSource;
		condVector[46:44] = condIn.shortcutDrain;
		condVector[47]    = condIn.aluDone;
		condVector[48]    = condIn.boostHigh;
		condVector[49]    = ~condIn.boostHigh;
		condVector[55:50] = condIn.currentFeedback;
		condVector[61:56] = ~condIn.currentFeedback;
		condVector[62]    = ownCurrent;
		condVector[63]    = ~ownCurrent;
	end

	assign condTrue = condVector[condCode];
endmodule
`default_nettype wire

/* rtl/relative_target.sv */
`timescale 1ns/1ps
`default_nettype none
module relative_target
	import jump_decoder_pkg::*;
#(
	parameter int PC_W = PC_WIDTH
) (
	input  wire logic [PC_W-1:0]         baseAddr,
	input  wire logic [OFFSET_WIDTH-1:0] offset,
	output logic [PC_W-1:0]              target
);
	logic [PC_W-1:0] offsetExt;

	// The offset is sign extended so a negative value walks back from the jump itself.
	assign offsetExt = PC_W'($signed(offset));
	assign target    = baseAddr + offsetExt;
endmodule
`default_nettype wire

/* rtl/microcore_jump_decoder.sv */
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module microcore_jump_decoder
	import jump_decoder_pkg::*;
#(
	parameter int PC_W = PC_WIDTH
) (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            instrValid,
	input  wire logic [15:0]     instrWord,
	input  wire logic [PC_W-1:0] instrAddr,
	input  wire logic [15:0]     flags,
	input  wire logic [3:0]      terminalCount,
	input  wire logic            aluDone,
	input  wire logic            startPin,
	input  wire logic [2:0]      shortcutDrainPin,
	input  wire logic [2:0]      shortcutSourcePin,
	input  wire logic            boostHighPin,
	input  wire logic [5:0]      currentFeedbackPin,
	output logic [PC_W-1:0]      programCounter,
	output logic                 pcValid,
	output logic                 branchTaken
);
	// Pin inputs pass two flip-flops before the condition logic sees them.
	localparam int PIN_W = 1 + 3 + 3 + 1 + 6;

	logic [PIN_W-1:0] pinMeta_reg;
	logic [PIN_W-1:0] pinSync_reg;
	logic [PIN_W-1:0] pinRaw;

	logic [2:0]       ownSelect_reg;
	logic [PC_W-1:0]  jumpReg0_reg;
	logic [PC_W-1:0]  jumpReg1_reg;
	jump_kind_e       lastKind_reg;

	jump_kind_e       kind;
	cond_inputs_s     condIn;
	logic             condTrue;
	logic [PC_W-1:0]  relTarget;
	logic [PC_W-1:0]  selectedJump;
	logic [PC_W-1:0]  pc_next;
	logic             taken;
	logic             selBit;

	logic             apbAccess;
	logic             apbDone;
	logic             addrHit;
	logic [31:0]      readData;

	assign pinRaw = {startPin, shortcutDrainPin, shortcutSourcePin, boostHighPin, currentFeedbackPin};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
		end
	end

	always_comb begin
		condIn.flags           = flags;
		condIn.terminalCount   = terminalCount;
		condIn.aluDone         = aluDone;
		condIn.startIn         = pinSync_reg[13];
		condIn.shortcutDrain   = pinSync_reg[12:10];
		condIn.shortcutSource  = pinSync_reg[9:7];
		condIn.boostHigh       = pinSync_reg[6];
		condIn.currentFeedback = pinSync_reg[5:0];
	end

	// The three patterns cannot overlap, so no priority among them is needed.
	always_comb begin
		kind = KIND_NONE;
		if (instrWord[15:4] == FAR_HI_CODE && instrWord[2:0] == FAR_LO_CODE) begin
			kind = KIND_FAR;
		end else if (instrWord[15:5] == REL_HI_CODE) begin
			kind = KIND_REL;
		end else if (instrWord[15:11] == COND_HI_CODE && instrWord[3:0] == COND_LO_CODE) begin
			kind = KIND_COND;
		end
	end

	assign selBit       = (kind == KIND_COND) ? instrWord[COND_SEL_BIT] : instrWord[FAR_SEL_BIT];
	assign selectedJump = selBit ? jumpReg1_reg : jumpReg0_reg;

	condition_select u_condition_select (
		.condIn    (condIn),
		.ownSelect (ownSelect_reg),
		.condCode  (instrWord[COND_CODE_LSB +: 6]),
		.condTrue  (condTrue)
	);

	relative_target #(
		.PC_W (PC_W)
	) u_relative_target (
		.baseAddr (instrAddr),
		.offset   (instrWord[OFFSET_WIDTH-1:0]),
		.target   (relTarget)
	);

	always_comb begin
		pc_next = instrAddr + PC_W'(1);
		taken   = 1'b0;
		case (kind)
			KIND_FAR: begin
				pc_next = selectedJump;
				taken   = 1'b1;
			end
			KIND_REL: begin
				// Bits 9..5 are part of the fixed opcode, so no polarity or feedback is consulted.
				pc_next = relTarget;
				taken   = 1'b1;
			end
			KIND_COND: begin
				if (condTrue) begin
					pc_next = selectedJump;
					taken   = 1'b1;
				end
			end
			default: begin
				taken = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			programCounter <= '0;
			branchTaken    <= 1'b0;
			lastKind_reg   <= KIND_NONE;
		end else if (instrValid) begin
			programCounter <= pc_next;
			branchTaken    <= taken;
			lastKind_reg   <= kind;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pcValid <= 1'b0;
		end else begin
			pcValid <= instrValid;
		end
	end

	// The slave inserts one wait state so that read data can come from a flip-flop.
	assign apbAccess = psel && penable;
	assign apbDone   = apbAccess && pready;
	assign addrHit   = (paddr == REG_CTRL) || (paddr == REG_JUMP0) || (paddr == REG_JUMP1) || (paddr == REG_STATUS);

	always_comb begin
		readData = 32'h0000_0000;
		case (paddr)
			REG_CTRL:   readData[2:0] = ownSelect_reg;
			REG_JUMP0:  readData[PC_W-1:0] = jumpReg0_reg;
			REG_JUMP1:  readData[PC_W-1:0] = jumpReg1_reg;
			REG_STATUS: readData = {13'h0000, lastKind_reg, branchTaken, 6'h00, 10'(programCounter)};
			default:    readData = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apbAccess && !pready;
			pslverr <= apbAccess && !pready && !addrHit;
			prdata  <= (apbAccess && !pready && !pwrite) ? readData : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ownSelect_reg <= OWN_SEL_RESET;
			jumpReg0_reg  <= '0;
			jumpReg1_reg  <= '0;
		end else if (apbDone && pwrite) begin
			case (paddr)
				REG_CTRL:  ownSelect_reg <= pwdata[2:0];
				REG_JUMP0: jumpReg0_reg  <= pwdata[PC_W-1:0];
				REG_JUMP1: jumpReg1_reg  <= pwdata[PC_W-1:0];
				default:   ownSelect_reg <= ownSelect_reg;
			endcase
		end
	end
endmodule
`default_nettype wire

/* verif/cond_source.sv */
`timescale 1ns/1ps
`default_nettype none
// Sources change just after an edge, as real ones do, so the pin synchronisers see clean levels.
module cond_source
	import jump_decoder_pkg::*;
(
	input  wire logic         clk,
	input  wire cond_inputs_s want,
	output cond_inputs_s      pins
);
	always_ff @(posedge clk) begin
		pins <= want;
	end
endmodule
`default_nettype wire

/* verif/jump_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module jump_monitor
	import jump_decoder_pkg::*;
#(
	parameter int PC_W = PC_WIDTH
) (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            instrValid,
	input  wire logic [15:0]     instrWord,
	input  wire logic [PC_W-1:0] instrAddr,
	input  wire logic [15:0]     flags,
	input  wire logic [3:0]      terminalCount,
	input  wire logic            aluDone,
	input  wire logic            boostHighPin,
	input  wire logic [PC_W-1:0] programCounter,
	input  wire logic            pcValid,
	input  wire logic            branchTaken
);
	wire logic [5:0]      code    = instrWord[10:5];
	wire logic            isFar   = instrWord[15:4] == 12'h39A && instrWord[2:0] == 3'h5;
	wire logic            isRel   = instrWord[15:5] == 11'h178;
	wire logic            go      = instrValid && instrWord[15:11] == 5'h07 && instrWord[3:0] == 4'h0;
	wire logic            flagHit = flags[code[3:0]] == code[4];
	wire logic            tcHit   = terminalCount[code[1:0]];
	wire logic [4:0]      offs    = instrWord[4:0];
	wire logic [PC_W-1:0] nextPc  = instrAddr + 1'b1;
	wire logic [PC_W-1:0] relPc   = instrAddr + PC_W'($signed(offs));
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_pc_latency: assert property (instrValid |=> pcValid)
		else $error("no pcValid after instruction");
	a_far_taken: assert property (instrValid && isFar |=> branchTaken)
		else $error("far jump not taken");
	a_rel_target: assert property (instrValid && isRel |=>
		branchTaken && programCounter == $past(relPc))
		else $error("relative target wrong");
	a_plain_next: assert property (instrValid && !isFar && !isRel && !go |=>
		!branchTaken && programCounter == $past(nextPc))
		else $error("plain word not sequential");
	a_untaken_next: assert property (go |=> branchTaken || programCounter == $past(nextPc))
		else $error("untaken branch not sequential");
	a_flag_cond: assert property (go && !code[5] |=> branchTaken == $past(flagHit))
		else $error("flag condition wrong");
	a_count_cond: assert property (go && code[5:2] == 4'h8 |=> branchTaken == $past(tcHit))
		else $error("terminal count condition wrong");
	a_alu_cond: assert property (go && code == 6'h2F |=> branchTaken == $past(aluDone))
		else $error("alu condition wrong");
	// The boost pin is synchronised, so the decision uses its level from two edges before the instruction.
	a_boost_cond: assert property (go && code == 6'h30 |=> branchTaken == $past(boostHighPin, 3))
		else $error("boost condition wrong");
endmodule
bind microcore_jump_decoder jump_monitor #(.PC_W(PC_W)) mon (.clk, .reset_n, .instrValid, .instrWord, .instrAddr,
	.flags, .terminalCount, .aluDone, .boostHighPin, .programCounter, .pcValid, .branchTaken);
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import jump_decoder_pkg::*;
;
	logic         clk, reset_n, psel, penable, pwrite, instrValid, pready, pslverr, pcValid, branchTaken, err;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [15:0]  instrWord;
	logic [9:0]   instrAddr, programCounter;
	cond_inputs_s want, pins;
	logic [34:0]  pat [4] = '{35'h5_5555_5555, 35'h2_AAAA_AAAA, 35'h3_3333_3333, 35'h4_CCCC_CCCC};
	logic [9:0]   jr [2] = '{10'h155, 10'h2AA};
	logic         t;
	int           nFail = 0, totalChecks = 0;
	cond_source src (.clk, .want, .pins);
	microcore_jump_decoder DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.instrValid, .instrWord, .instrAddr, .flags(pins.flags), .terminalCount(pins.terminalCount),
		.aluDone(pins.aluDone), .startPin(pins.startIn), .shortcutDrainPin(pins.shortcutDrain),
		.shortcutSourcePin(pins.shortcutSource), .boostHighPin(pins.boostHigh),
		.currentFeedbackPin(pins.currentFeedback), .programCounter, .pcValid, .branchTaken);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic cmp(input logic [31:0] g, e);
		totalChecks++;
		if (g !== e) begin
			nFail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge clk);
		if (i == 20) begin
			nFail++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic instr(input logic [15:0] w, input logic [9:0] a, e, input logic tk);
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= w;
		instrAddr <= a;
		#1;
		cmp(pcValid, 1'b0);
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
		cmp(pcValid, 1'b1);
		cmp(programCounter, e);
		cmp(branchTaken, tk);
	endtask
	// Truth of every condition code with own select at its reset value 0, indexed by the code itself.
	function automatic logic expc(input cond_inputs_s s, input int c);
		logic [63:0] v;
		v = {~s.currentFeedback[0], s.currentFeedback[0], ~s.currentFeedback, s.currentFeedback, ~s.boostHigh,
			s.boostHigh, s.aluDone, s.shortcutDrain, ~s.shortcutSource, ~s.shortcutDrain, s.startIn, ~s.startIn,
			s.terminalCount, s.flags, ~s.flags};
		return v[c];
	endfunction
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, instrValid, instrWord, instrAddr} = '0;
		want = '0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, 8'h0C, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		cmp(err, 1'b1);
		apb(1'b1, 8'h04, jr[0]);
		apb(1'b1, 8'h08, jr[1]);
		apb(1'b0, 8'h08, 32'h0);
		cmp(rd, jr[1]);
		$display("test registers done");
		instr({12'h39A, 1'b0, 3'h5}, 10'h010, jr[0], 1'b1);
		instr({12'h39A, 1'b1, 3'h5}, 10'h011, jr[1], 1'b1);
		instr({12'h39A, 1'b0, 3'h4}, 10'h3FF, 10'h000, 1'b0);
		instr({11'h178, 5'h10}, 10'h005, 10'h3F5, 1'b1);
		instr({11'h178, 5'h0F}, 10'h3FA, 10'h009, 1'b1);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		cmp(rd, 32'h0005_0009);
		instr({11'h179, 5'h0F}, 10'h020, 10'h021, 1'b0);
		$display("test jumps done");
		for (int p = 0; p < 4; p++) begin
			@(posedge clk);
			want <= pat[p];
			repeat (4) @(posedge clk);
			for (int c = 0; c < 64; c++) begin
				t = expc(pat[p], c);
				instr({5'h07, 6'(c), c[0], 4'h0}, 10'h3FF, t ? jr[c[0]] : 10'h000, t);
			end
		end
		$display("test conditions done");
		// The last pattern leaves current feedback 2 high and feedback 0 low, so own select 2 differs from 0.
		apb(1'b1, 8'h00, 32'h0000_0002);
		apb(1'b0, 8'h00, 32'h0000_0000);
		cmp(rd, 32'h0000_0002);
		instr({5'h07, 6'h3E, 1'b0, 4'h0}, 10'h3FF, jr[0], 1'b1);
		instr({5'h07, 6'h3F, 1'b1, 4'h0}, 10'h3FF, 10'h000, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0006);
		instr({5'h07, 6'h3E, 1'b0, 4'h0}, 10'h3FF, 10'h000, 1'b0);
		instr({5'h07, 6'h3F, 1'b1, 4'h0}, 10'h3FF, jr[1], 1'b1);
		$display("test own select done");
		stop_test();
	end
endmodule
`default_nettype wire
